// file: design/dprf_regfile.sv
// Multiport primary register file of the core with AHB-Lite access
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// [RL1] Float writes use all forty bits
// [RL2] Integer writes keep bits 39..32
// [RL3] Pointers read by core, updated by both units
// [RL4] Pointers also general registers for core
// [RL5] Low eight page bits select page
// [RL6] 256 pages of 64K words
// [RL7] Index steps feed the address unit
// [RL8] Circular size feeds the address unit
// [RL9] Stack pointer names last pushed element
// [RL10] Push preincrements, pop postdecrements
// [RL11] Only stack operations move stack pointer (core and bus writes also load it here)
// [RL12] Results update condition flags normally
// [RL13] Loading flags copies source exactly
// [RL14] Enables at bits 10..0 and 26..16
// [RL15] One enables, zero disables interrupt
// [RL16] Pending bit one means interrupt set
// [RL17] Flag pins configurable and readable
// [RL18] Count holds block repeat iterations
// [RL19] Head and last hold block bounds
// [RL20] All registers usable by core units
// [RL21] Two read buses every cycle
// [RL22] Fixed priority on same-register writes
module dprf_regfile
    import dprf_pkg::*;
#(
    parameter int FLAG_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // AHB-Lite register access
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core read buses
    input wire logic [4:0] register_read_bus_a_idx,
    input wire logic [4:0] register_read_bus_b_idx,
    output logic [39:0] register_read_bus_a,
    output logic [39:0] register_read_bus_b,
    // Core write port
    input wire logic core_we,
    input wire logic [4:0] core_widx,
    input wire logic core_float,
    input wire logic [39:0] core_wdata,
    // Condition flag update
    input wire logic flag_upd,
    input wire logic [FLAG_W-1:0] flag_cond,
    // Address arithmetic unit 0
    input wire logic aru0_we,
    input wire logic [2:0] aru0_idx,
    input wire logic [31:0] aru0_wdata,
    // Address arithmetic unit 1
    input wire logic aru1_we,
    input wire logic [2:0] aru1_idx,
    input wire logic [31:0] aru1_wdata,
    // Stack operations
    input wire logic stack_push,
    input wire logic stack_pop,
    // Interrupt sources
    input wire logic [31:0] irq_set,
    // System register views
    output logic [7:0] page_number,
    output logic [31:0] index_step_0,
    output logic [31:0] index_step_1,
    output logic [31:0] circular_size,
    output logic [31:0] stack_top_ptr,
    output logic [31:0] irq_active,
    // Repeat block registers
    output logic [31:0] loop_iteration_count,
    output logic [31:0] loop_head_addr,
    output logic [31:0] loop_last_addr,
    // Flag pin 0
    input wire logic flag_pin_0_i,
    output logic flag_pin_0_o,
    output logic flag_pin_0_oe,
    // Flag pin 1
    input wire logic flag_pin_1_i,
    output logic flag_pin_1_o,
    output logic flag_pin_1_oe
);
    // Register storage, one forty-bit slot per register
    logic [39:0] regs_ff [NREG];
    logic [39:0] nxt_reg [NREG];
    // Read bus output registers
    logic [39:0] rd_a_ff;
    logic [39:0] rd_b_ff;
    // Flag pin synchronisers
    logic [1:0] pin_s1_ff;
    logic [1:0] pin_s2_ff;
    // Bus data phase state
    logic wr_pend_ff;
    logic rd_pend_ff;
    logic [5:0] baddr_ff;
    logic bok_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    // Registered interrupt view
    logic [31:0] irq_act_ff;

    // Bus decode
    // Size is not decoded, every access is a word
    // Live request seen in an address phase
    wire ahb_go = hsel && htrans[1] && hready;
    // Only the low 256 bytes decode
    wire addr_ok = (haddr[31:8] == 24'h00_0000);
    // Write lands in its data phase
    wire bus_we = wr_pend_ff && bok_ff;
    // Low words and extension bytes
    wire lo_word = (baddr_ff < 6'(NREG));
    wire hi_word = (baddr_ff >= BUS_EXT0) && (baddr_ff < (BUS_EXT0 + 6'h08));
    // Registers behind the held address
    wire [39:0] lo_reg = regs_ff[baddr_ff[4:0]];
    wire [39:0] hi_reg = regs_ff[{2'b00, baddr_ff[2:0]}];
    // Unmapped words read zero
    wire [31:0] bus_rdata = !bok_ff ? 32'h0000_0000 :
                            lo_word ? lo_reg[31:0] :
                            hi_word ? {24'h00_0000, hi_reg[39:32]} : 32'h0000_0000;
    // Stack moves only on a lone push or pop
    wire stk_move = stack_push ^ stack_pop;
    wire [31:0] sp_cur = regs_ff[IDX_STACK][31:0];
    // [RL10] Preincrement and postdecrement
    wire [31:0] sp_next = stack_push ? (sp_cur + 32'h0000_0001) : (sp_cur - 32'h0000_0001);

    // Per-register write selection
    for (genvar g = 0; g < NREG; g++) begin : g_reg
        // Accumulators are the first eight
        wire is_acc = (g < 8);
        // [RL4] [RL20] Core reaches every register
        wire core_hit = core_we && (core_widx == 5'(g));
        // [RL3] Both address units reach pointers
        wire a0_hit = aru0_we && (5'(g) == (IDX_AUX0 + {2'b00, aru0_idx}));
        wire a1_hit = aru1_we && (5'(g) == (IDX_AUX0 + {2'b00, aru1_idx}));
        // [RL11] Stack pointer moved by stack ops
        wire stk_hit = stk_move && (5'(g) == IDX_STACK);
        // Bus writes, low word or extension byte
        wire blo_hit = bus_we && lo_word && (baddr_ff[4:0] == 5'(g));
        wire bhi_hit = bus_we && hi_word && is_acc && (baddr_ff[2:0] == 3'(g));
        // [RL1] [RL2] Float writes full width, integer keeps top byte
        wire [39:0] core_val = (core_float || !is_acc) ? core_wdata :
                               {regs_ff[g][39:32], core_wdata[31:0]};
        // [RL22] Core, stack, unit 1, unit 0, then bus
        wire [39:0] pick = core_hit ? core_val :
                           stk_hit ? {8'h00, sp_next} :
                           a1_hit ? {regs_ff[g][39:32], aru1_wdata} :
                           a0_hit ? {regs_ff[g][39:32], aru0_wdata} :
                           blo_hit ? {regs_ff[g][39:32], hwdata} :
                           bhi_hit ? {hwdata[7:0], regs_ff[g][31:0]} : regs_ff[g];
        // [RL12] Condition flags replaced below a core load; a bus write loses to the update
        wire flag_hit = flag_upd && !core_hit && (5'(g) == IDX_FLAGS);
        wire [39:0] flg = flag_hit ? {pick[39:FLAG_W], flag_cond} : pick;
        // Only accumulators keep the upper byte
        wire [31:0] w32 = flg[31:0];
        // [RL14] Unused enable bits read zero
        wire [31:0] m32 = (5'(g) == IDX_MASK) ? (w32 & MASK_BITS) : w32;
        // [RL16] Hardware set wins over clear
        wire [31:0] p32 = (5'(g) == IDX_PEND) ? (m32 | irq_set) : m32;
        // [RL17] Pin levels are read-only bits
        wire [31:0] f32 = (5'(g) != IDX_FPC) ? p32 :
                          ((p32 & FPC_WMASK) | (32'(pin_s2_ff[0]) << FPC_IN0) |
                           (32'(pin_s2_ff[1]) << FPC_IN1));
        // Non-accumulators hold 32 bits
        assign nxt_reg[g] = is_acc ? flg : {8'h00, f32};

        // Storage update
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                // All registers clear
                regs_ff[g] <= REG_RST;
            end else begin
                regs_ff[g] <= nxt_reg[g];
            end
        end
    end

    // [RL21] Two registered read buses
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // Buses read zero in reset
            rd_a_ff <= REG_RST;
            rd_b_ff <= REG_RST;
        end else begin
            // Out-of-range index reads zero
            rd_a_ff <= (register_read_bus_a_idx < 5'(NREG)) ?
                       regs_ff[register_read_bus_a_idx] : REG_RST;
            rd_b_ff <= (register_read_bus_b_idx < 5'(NREG)) ?
                       regs_ff[register_read_bus_b_idx] : REG_RST;
        end
    end

    // Flag pin two-stage synchroniser
    // Only the second stage feeds logic
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // Pins read low in reset
            pin_s1_ff <= 2'h0;
            pin_s2_ff <= 2'h0;
        end else begin
            pin_s1_ff <= {flag_pin_1_i, flag_pin_0_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // [RL15] Enabled pending interrupts
    // Uses next values so the view has no lag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // Reset clears the view
            irq_act_ff <= 32'h0000_0000;
        end else begin
            irq_act_ff <= nxt_reg[IDX_PEND][31:0] & nxt_reg[IDX_MASK][31:0];
        end
    end

    // Bus phases: reads take one wait state, writes none
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // Ready high, no transfer pending
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            baddr_ff <= 6'h00;
            bok_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            wr_pend_ff <= ahb_go && hwrite;
            rd_pend_ff <= ahb_go && !hwrite;
            // A read holds ready low one cycle
            hreadyout_ff <= !(ahb_go && !hwrite);
            // Remember the address phase
            if (ahb_go) begin
                baddr_ff <= haddr[7:2];
                bok_ff <= addr_ok;
            end
            // Capture read data in the wait cycle
            if (rd_pend_ff) begin
                hrdata_ff <= bus_rdata;
            end
        end
    end

    // Output wiring, all straight from flops
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign register_read_bus_a = rd_a_ff;
    assign register_read_bus_b = rd_b_ff;
    // [RL5] [RL6] Page number for 64K-word pages
    assign page_number = regs_ff[IDX_PAGE][PAGE_W-1:0];
    // [RL7] Index steps to the address unit
    assign index_step_0 = regs_ff[IDX_STEP0][31:0];
    assign index_step_1 = regs_ff[IDX_STEP1][31:0];
    // [RL8] Circular block size
    assign circular_size = regs_ff[IDX_CIRC][31:0];
    // [RL9] Address of last pushed element
    assign stack_top_ptr = regs_ff[IDX_STACK][31:0];
    // Interrupt view
    assign irq_active = irq_act_ff;
    // [RL18] [RL19] Block repeat registers
    assign loop_iteration_count = regs_ff[IDX_COUNT][31:0];
    assign loop_head_addr = regs_ff[IDX_HEAD][31:0];
    assign loop_last_addr = regs_ff[IDX_LAST][31:0];
    // [RL17] Pin drivers from control bits
    assign flag_pin_0_o = regs_ff[IDX_FPC][FPC_OUT0];
    assign flag_pin_0_oe = regs_ff[IDX_FPC][FPC_DIR0];
    assign flag_pin_1_o = regs_ff[IDX_FPC][FPC_OUT1];
    assign flag_pin_1_oe = regs_ff[IDX_FPC][FPC_DIR1];

    // Properties clock on mclk and stop in reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // [RL1] Float load fills all bits
    AST_FLOAT_FULL: assert property (core_we && core_float && core_widx < 5'h08 // [RL1]
        |=> regs_ff[$past(core_widx)] == $past(core_wdata))
        else $error("float load lost bits");

    // [RL2] Integer load keeps top byte
    AST_INT_KEEP: assert property (core_we && !core_float && core_widx < 5'h08 // [RL2]
        |=> regs_ff[$past(core_widx)][39:32] == $past(regs_ff[core_widx][39:32])
            && regs_ff[$past(core_widx)][31:0] == $past(core_wdata[31:0]))
        else $error("int load bad");

    // [RL3] Unit 1 updates a pointer
    AST_ARU_UPD: assert property (aru1_we && !core_we && !stk_move // [RL3]
        |=> regs_ff[IDX_AUX0 + {2'b00, $past(aru1_idx)}][31:0] == $past(aru1_wdata))
        else $error("pointer update lost");

    // [RL10] Push increments by one
    AST_PUSH: assert property (stack_push && !stack_pop // [RL10]
        && !(core_we && core_widx == IDX_STACK)
        |=> stack_top_ptr == $past(stack_top_ptr) + 32'h0000_0001) else $error("push bad");

    // [RL11] Pop decrements by one
    AST_POP: assert property (stack_pop && !stack_push // [RL11]
        && !(core_we && core_widx == IDX_STACK)
        |=> stack_top_ptr == $past(stack_top_ptr) - 32'h0000_0001) else $error("pop bad");

    // [RL13] Flags load copies the source
    AST_FLAG_LOAD: assert property (core_we && core_widx == IDX_FLAGS // [RL13]
        |=> regs_ff[IDX_FLAGS][31:0] == $past(core_wdata[31:0]))
        else $error("flags load bad");

    // [RL14] Reserved enable bits stay zero
    AST_MASK_RSV: assert property ((regs_ff[IDX_MASK][31:0] & ~MASK_BITS) == 32'h0000_0000) // [RL14]
        else $error("mask reserved set");

    // [RL16] Set beats clear
    AST_PEND_SET: assert property (irq_set[0] |=> regs_ff[IDX_PEND][0]) // [RL16]
        else $error("pending set lost");

    // [RL15] Active only when enabled
    AST_IRQ_GATE: assert property (##1 irq_active == (regs_ff[IDX_PEND][31:0] & // [RL15]
        regs_ff[IDX_MASK][31:0])) else $error("irq gate wrong");

    // [RL21] Read bus shows register a cycle later
    AST_RDBUS: assert property (register_read_bus_a_idx < 5'(NREG) // [RL21]
        |=> register_read_bus_a == $past(regs_ff[register_read_bus_a_idx]))
        else $error("read bus wrong");

    // [RL17] Pin level reaches control after three edges
    AST_PIN_IN: assert property ($rose(flag_pin_0_i) ##1 flag_pin_0_i [*3] // [RL17]
        |-> regs_ff[IDX_FPC][FPC_IN0]) else $error("pin level missing");

    // [RL21] Second read bus a cycle later
    AST_RDBUS_B: assert property (register_read_bus_b_idx < 5'(NREG) // [RL21]
        |=> register_read_bus_b == $past(regs_ff[register_read_bus_b_idx]))
        else $error("read bus b wrong");

    // [RL11] Pointer still without a stack operation
    AST_STK_HOLD: assert property (!stk_move // [RL11]
        && !(core_we && core_widx == IDX_STACK)
        && !(bus_we && baddr_ff == {1'b0, IDX_STACK})
        |=> stack_top_ptr == $past(stack_top_ptr)) else $error("stack moved");

    // [RL12] Flag update lands in the low bits
    AST_FLAG_UPD: assert property (flag_upd && !(core_we && core_widx == IDX_FLAGS) // [RL12]
        |=> regs_ff[IDX_FLAGS][FLAG_W-1:0] == $past(flag_cond))
        else $error("flag update lost");

    // [RL3] Unit 0 updates a pointer
    AST_ARU0_UPD: assert property (aru0_we && !aru1_we && !core_we && !stk_move // [RL3]
        |=> regs_ff[IDX_AUX0 + {2'b00, $past(aru0_idx)}][31:0] == $past(aru0_wdata))
        else $error("unit 0 update lost");

    // [RL5] Bus write reaches the page number
    AST_PAGE_LAND: assert property (bus_we && !core_we && baddr_ff == {1'b0, IDX_PAGE} // [RL5]
        |=> page_number == $past(hwdata[PAGE_W-1:0])) else $error("page write lost");

    // [RL4] Pointer three keeps no top byte
    AST_PTR_TOP: assert property (regs_ff[IDX_AUX0 + 5'h03][39:32] == 8'h00) // [RL4]
        else $error("pointer top byte set");

    // [RL20] Writes take no wait state
    AST_WR_NOWAIT: assert property (ahb_go && hwrite |=> hreadyout) // [RL20]
        else $error("write stalled");

    // [RL20] Reads take exactly one wait state
    AST_RD_WAIT: assert property (ahb_go && !hwrite |=> !hreadyout ##1 hreadyout) // [RL20]
        else $error("read wait wrong");

    // [RL20] Every response is OKAY
    AST_HRESP_OK: assert property (hresp == 1'b0) // [RL20]
        else $error("error response");

    // [RL17] Second pin level reaches control
    AST_PIN1_IN: assert property ($rose(flag_pin_1_i) ##1 flag_pin_1_i [*3] // [RL17]
        |-> regs_ff[IDX_FPC][FPC_IN1]) else $error("pin 1 level missing");
endmodule : dprf_regfile
`default_nettype wire

// file: design/dprf_pkg.sv
// Constants shared by the core register file
package dprf_pkg;
    // Register count and index width
    localparam int NREG = 28;
    localparam int IDX_W = 5;
    localparam int ACC_W = 40;
    localparam int WORD_W = 32;
    // Register indices
    localparam logic [4:0] IDX_ACC0 = 5'h00;
    localparam logic [4:0] IDX_AUX0 = 5'h08;
    localparam logic [4:0] IDX_PAGE = 5'h10;
    localparam logic [4:0] IDX_STEP0 = 5'h11;
    localparam logic [4:0] IDX_STEP1 = 5'h12;
    localparam logic [4:0] IDX_CIRC = 5'h13;
    localparam logic [4:0] IDX_STACK = 5'h14;
    localparam logic [4:0] IDX_FLAGS = 5'h15;
    localparam logic [4:0] IDX_MASK = 5'h16;
    localparam logic [4:0] IDX_PEND = 5'h17;
    localparam logic [4:0] IDX_FPC = 5'h18;
    localparam logic [4:0] IDX_HEAD = 5'h19;
    localparam logic [4:0] IDX_LAST = 5'h1a;
    localparam logic [4:0] IDX_COUNT = 5'h1b;
    // Bus word index of the first accumulator extension byte
    localparam logic [5:0] BUS_EXT0 = 6'h20;
    // Reset value of every register
    localparam logic [39:0] REG_RST = 40'h00_0000_0000;
    // Writable interrupt enable bits: CPU 10..0, DMA 26..16
    localparam logic [31:0] MASK_BITS = 32'h07ff_07ff;
    // Flag pin control layout
    localparam int FPC_DIR0 = 0;
    localparam int FPC_OUT0 = 1;
    localparam int FPC_IN0 = 2;
    localparam int FPC_DIR1 = 4;
    localparam int FPC_OUT1 = 5;
    localparam int FPC_IN1 = 6;
    localparam logic [31:0] FPC_WMASK = 32'h0000_0033;
    // Page number width for direct addressing
    localparam int PAGE_W = 8;
endpackage : dprf_pkg

// file: testbench/dprf_core_model.sv
// Core-side model: core, address-unit, stack and flag strobes and read ports around the register file
`timescale 1ns/1ps
`default_nettype none
module dprf_core_model (
    input wire logic mclk,
    output logic [6:0] strb,
    output logic [4:0] core_widx,
    output logic [39:0] core_wdata,
    output logic [7:0] flag_cond,
    output logic [2:0] aru_idx,
    output logic [31:0] aru0_wdata,
    output logic [31:0] aru1_wdata,
    output logic [4:0] rd_a_idx,
    output logic [4:0] rd_b_idx,
    input wire logic [39:0] rd_a,
    input wire logic [39:0] rd_b
);
    // Idle at time zero
    initial begin
        strb = 7'h00;
        core_widx = 5'h00;
        core_wdata = 40'h00_0000_0000;
        flag_cond = 8'h00;
        aru_idx = 3'h0;
        aru0_wdata = 32'h0000_0000;
        aru1_wdata = 32'h0000_0000;
        rd_a_idx = 5'h00;
        rd_b_idx = 5'h00;
    end
    // One cycle of strobes {float, core, unit1, unit0, push, pop, flag}
    // units carry distinct data
    task automatic step(input logic [6:0] s, input logic [4:0] wi, input logic [39:0] wd);
        strb <= s;
        core_widx <= wi;
        core_wdata <= wd;
        flag_cond <= wd[7:0];
        aru_idx <= wi[2:0];
        aru0_wdata <= wd[31:0];
        aru1_wdata <= ~wd[31:0];
        @(posedge mclk);
        // Released data lines except flag_cond show the inverse, never a stale copy
        strb <= 7'h00;
        core_wdata <= ~wd;
        aru0_wdata <= ~wd[31:0];
        aru1_wdata <= wd[31:0];
    endtask : step
    task automatic peek(input logic [4:0] ia, input logic [4:0] ib,
                        output logic [39:0] va, output logic [39:0] vb);
        rd_a_idx <= ia;
        rd_b_idx <= ib;
        @(posedge mclk);
        @(posedge mclk);
        va = rd_a;
        vb = rd_b;
    endtask : peek
endmodule : dprf_core_model
`default_nettype wire

// file: testbench/test_dsp_cpu_primary_register_file.sv
// Self-checking bench for the core register file
`timescale 1ns/1ps
`default_nettype none
module test_dsp_cpu_primary_register_file;
    import dprf_pkg::*;
    // Bench-driven inputs
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [1:0] pin_lvl = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, irq_set = 32'h0;
    // Observed outputs and model wiring
    logic hrdy, hresp;
    logic [1:0] po, poe;
    logic [7:0] page_w, fcond;
    logic [6:0] strb;
    logic [4:0] widx, ra_i, rb_i;
    logic [2:0] aidx;
    logic [31:0] hrdata, step0, step1, circ, stk, irq_act, cnt, head, last, q, a0d, a1d;
    logic [39:0] wdat, rd_a, rd_b, va, vb;
    wire logic [1:0] pin = {poe[1] ? po[1] : pin_lvl[1], poe[0] ? po[0] : pin_lvl[0]};
    int num_errors = 0;
    int num_checks = 0;
    // Free-running clock
    always #20 mclk = ~mclk;
    dprf_regfile i_dprf_regfile (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .register_read_bus_a_idx(ra_i),
        .register_read_bus_b_idx(rb_i), .register_read_bus_a(rd_a), .register_read_bus_b(rd_b),
        .core_we(strb[5]), .core_widx(widx), .core_float(strb[6]), .core_wdata(wdat),
        .flag_upd(strb[0]), .flag_cond(fcond), .aru0_we(strb[3]), .aru0_idx(aidx),
        .aru0_wdata(a0d), .aru1_we(strb[4]), .aru1_idx(aidx), .aru1_wdata(a1d),
        .stack_push(strb[2]), .stack_pop(strb[1]), .irq_set(irq_set), .page_number(page_w),
        .index_step_0(step0), .index_step_1(step1), .circular_size(circ),
        .stack_top_ptr(stk), .irq_active(irq_act), .loop_iteration_count(cnt),
        .loop_head_addr(head), .loop_last_addr(last), .flag_pin_0_i(pin[0]),
        .flag_pin_0_o(po[0]), .flag_pin_0_oe(poe[0]), .flag_pin_1_i(pin[1]),
        .flag_pin_1_o(po[1]), .flag_pin_1_oe(poe[1]));
    dprf_core_model i_dprf_core_model (.mclk(mclk), .strb(strb), .core_widx(widx),
        .core_wdata(wdat), .flag_cond(fcond), .aru_idx(aidx), .aru0_wdata(a0d),
        .aru1_wdata(a1d), .rd_a_idx(ra_i), .rd_b_idx(rb_i), .rd_a(rd_a), .rd_b(rd_b));
    // Compare and count
    task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Byte address of a bus word
    function automatic logic [31:0] ba(input logic [5:0] w);
        return {24'h0, w, 2'b00};
    endfunction : ba
    // Wait for hready at a rising edge, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hrdy !== 1'b1 && n < 64);
        if (hrdy !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask : wait_rdy
    // Single AHB-Lite word transfer, read data left in q
    task automatic ahb(input logic wr, input logic [5:0] w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ba(w);
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : ahb
    // Counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        ahb(1'b1, {1'b0, IDX_PAGE}, 32'h1234_56ab);
        ahb(1'b1, {1'b0, IDX_COUNT}, 32'h0000_0010);
        ahb(1'b1, {1'b0, IDX_HEAD}, 32'h0000_4000);
        ahb(1'b1, {1'b0, IDX_LAST}, 32'h0000_40ff);
        ahb(1'b1, {1'b0, IDX_STEP1}, 32'hffff_fffe);
        ahb(1'b1, {1'b0, IDX_CIRC}, 32'h0000_0040);
        ahb(1'b1, {1'b0, IDX_STEP0}, 32'h0000_0003);
        ahb(1'b1, 6'h28, 32'hffff_ffff);
        @(posedge mclk);
        chk("page", 40'(page_w), 40'hab);
        chk("count", 40'(cnt), 40'h10);
        chk("head", 40'(head), 40'h4000);
        chk("last", 40'(last), 40'h40ff);
        chk("step1", 40'(step1), 40'hffff_fffe);
        chk("circ", 40'(circ), 40'h40);
        chk("step0", 40'(step0), 40'h3);
        ahb(1'b0, {1'b0, IDX_PAGE}, 32'h0);
        chk("page read", 40'(q), 40'h1234_56ab);
        chk("okay", 40'(hresp), 40'h0);
        ahb(1'b0, 6'h28, 32'h0);
        chk("unmapped", 40'(q), 40'h0);
        $display("test registers done");
        i_dprf_core_model.step(7'h60, 5'd2, 40'hab_1234_5678);
        i_dprf_core_model.peek(5'd2, 5'd2, va, vb);
        chk("float acc", va, 40'hab_1234_5678);
        i_dprf_core_model.step(7'h20, 5'd2, 40'h00_cafe_f00d);
        i_dprf_core_model.peek(5'd2, 5'd2, va, vb);
        chk("int acc", vb, 40'hab_cafe_f00d);
        ahb(1'b0, BUS_EXT0 + 6'd2, 32'h0);
        chk("acc ext", 40'(q), 40'hab);
        i_dprf_core_model.step(7'h08, 5'd11, 40'h00_00ff_0010);
        i_dprf_core_model.peek(5'd11, 5'd11, va, vb);
        chk("unit0", vb, 40'h00ff_0010);
        i_dprf_core_model.step(7'h38, 5'd11, 40'h77_1357_9bdf);
        i_dprf_core_model.peek(5'd11, 5'd11, va, vb);
        chk("core wins", va, 40'h1357_9bdf);
        i_dprf_core_model.step(7'h18, 5'd11, 40'h00_1357_9bdf);
        i_dprf_core_model.peek(5'd11, 5'd11, va, vb);
        chk("unit1 wins", va, 40'heca8_6420);
        $display("test core writes done");
        ahb(1'b1, {1'b0, IDX_STACK}, 32'h0000_0100);
        i_dprf_core_model.step(7'h04, 5'd0, 40'h0);
        @(posedge mclk);
        chk("push", 40'(stk), 40'h101);
        i_dprf_core_model.step(7'h06, 5'd0, 40'h0);
        @(posedge mclk);
        chk("push pop", 40'(stk), 40'h101);
        i_dprf_core_model.step(7'h02, 5'd0, 40'h0);
        @(posedge mclk);
        chk("pop", 40'(stk), 40'h100);
        i_dprf_core_model.step(7'h20, IDX_FLAGS, 40'hff_a5a5_0f0f);
        i_dprf_core_model.peek(IDX_FLAGS, IDX_FLAGS, va, vb);
        chk("flags load", va, 40'ha5a5_0f0f);
        i_dprf_core_model.step(7'h01, 5'd0, 40'h3c);
        i_dprf_core_model.peek(IDX_FLAGS, IDX_FLAGS, va, vb);
        chk("flags update", va, 40'ha5a5_0f3c);
        $display("test stack and flags done");
        ahb(1'b1, {1'b0, IDX_MASK}, 32'hffff_ffff);
        ahb(1'b0, {1'b0, IDX_MASK}, 32'h0);
        chk("mask bits", 40'(q), 40'h07ff_07ff);
        irq_set <= 32'h8001_0403;
        @(posedge mclk);
        irq_set <= 32'h0;
        repeat (2) @(posedge mclk);
        chk("irq on", 40'(irq_act), 40'h0001_0403);
        ahb(1'b1, {1'b0, IDX_MASK}, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chk("irq masked", 40'(irq_act), 40'h1);
        ahb(1'b0, {1'b0, IDX_PEND}, 32'h0);
        chk("pending", 40'(q), 40'h8001_0403);
        pin_lvl <= 2'b10;
        ahb(1'b1, {1'b0, IDX_FPC}, 32'h0000_0023);
        repeat (4) @(posedge mclk);
        chk("pin drive", 40'({poe, po}), 40'h7);
        ahb(1'b0, {1'b0, IDX_FPC}, 32'h0);
        chk("pin read", 40'(q), 40'h67);
        $display("test interrupts and pins done");
        stop_test();
    end
endmodule : test_dsp_cpu_primary_register_file
`default_nettype wire
